// File: osst_top.sv
// Oscillator selection, trim load and start-up timer for the clock controller.
//
// Contract
// (R1) One bit selects RC 8MHz or 1MHz.
// (R2) RC frequency bit resets to 1 for 0110.
// (R3) RC runs when it clocks system or PLL.
// (R4) RC off for 0011, 0100, 0101, 1100, 1101.
// (R5) Calibration byte loaded into trim at reset.
// (R6) Software writes to trim retune the RC.
// (R7) Watchdog and reset time-out keep watchdog oscillator.
// (R8) Divide-by-eight option divides system clock by 8.
// (R9) RC start-up: 6 clocks wake, reset delays.
// (R10) Reset pin disabled stretches code 00 delay; the code does so only for the RC 8MHz and 1MHz sources.
// (R11) 128 kHz start-up: 6 clocks, 4ms or 64ms.
// (R12) Source code from fuses or selection register.
// (R13) Upper source bits give crystal range.
// (R14) Lowest crystal range only with ceramic resonators.
// (R15) Crystal start-up from bit 0 and code.
// (R16) 258-clock options never with crystals.
// (R17) 1024-clock options meant for ceramic resonators.
// (R18) Wake count timed on selected source clocks.
// (R19) Millisecond delay counted on watchdog oscillator.
// (R20) Core clock gated until all counters finish.
`timescale 1ns/1ps

module osst_top #(
    parameter int WAKE_W = 15,
    parameter int WD_W = 14
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Non-volatile configuration.
    input wire logic [3:0] clock_source_fuses,
    input wire logic [1:0] startup_time_fuses,
    input wire logic divide_by_eight_fuse,
    input wire logic reset_pin_disable_fuse,
    input wire logic [7:0] factory_trim,
    // Oscillator clock ticks, one cycle each, synchronous to core_clk.
    input wire logic src_tick,
    input wire logic wd_tick,
    // Start request: wake from power-down or a newly enabled source.
    input wire logic wake_req,
    // Register port.
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Oscillator controls.
    output logic rc_enable,
    output logic rc_freq_select,
    output logic [7:0] osc_trim,
    output logic [2:0] xtal_range,
    output logic wd_osc_enable,
    output logic sys_clk_en,
    output logic core_clk_gate
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers and state.

    logic [7:0] osc_trim_reg_r;
    logic [7:0] mcu_control_reg_r;
    logic [7:0] clock_select_reg_r;
    logic [WAKE_W-1:0] wake_cnt_r;
    logic [WAKE_W-1:0] wake_cnt_nxt;
    logic [WD_W-1:0] wd_cnt_r;
    logic [WD_W-1:0] wd_cnt_nxt;
    logic [2:0] div_cnt_r;
    logic load_pending_r;
    logic reset_start_r;
    logic [7:0] reg_rdata_r;
    osst_pkg::osst_state_e state_r;
    osst_pkg::osst_state_e state_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Source selection and decode.

    wire logic use_reg;
    wire logic [3:0] src_code;
    wire logic [1:0] startup_code;
    wire logic rc_off_code;
    wire logic is_rc;
    wire logic is_wd;
    wire logic is_xtal;
    wire logic [2:0] xtal_key;
    osst_pkg::osst_sel_s sel;

    // The selection register overrides the fuses once software sets its enable bit.
    assign use_reg = clock_select_reg_r[osst_pkg::SEL_USE_REG_BIT];
    assign src_code = use_reg ? clock_select_reg_r[osst_pkg::SEL_FIELD_LO +: 4]
                              : clock_source_fuses; // [R12]
    assign startup_code = use_reg ? clock_select_reg_r[osst_pkg::STARTUP_FIELD_LO +: 2]
                                  : startup_time_fuses; // [R12]

    // Every code not listed here keeps the RC running, the external clock and crystal codes included.
    assign rc_off_code = (src_code == osst_pkg::SRC_WD_128K) || (src_code == osst_pkg::SRC_PLL_XTAL)
        || (src_code == osst_pkg::SRC_PLL_EXT) || (src_code == osst_pkg::SRC_XTAL_C)
        || (src_code == osst_pkg::SRC_XTAL_D); // [R4]
    assign is_rc = (src_code == osst_pkg::SRC_RC_8M) || (src_code == osst_pkg::SRC_RC_1M);
    assign is_wd = (src_code == osst_pkg::SRC_WD_128K);
    assign is_xtal = src_code[3] || (src_code == 4'h7);
    assign xtal_key = {src_code[0], startup_code};

    // Table lookup for start-up counts; the combinational decode keeps one place for all sources.
    always_comb begin
        sel = '0;
        sel.rc_on = !rc_off_code; // [R3]
        sel.xtal_range = is_xtal ? src_code[3:1] : 3'h0; // [R13]
        sel.wake_cycles = osst_pkg::WAKE_CK_SHORT; // [R9] [R11]
        if (is_xtal) begin
            unique case (xtal_key) // [R15]
                3'h0: begin
                    sel.wake_cycles = osst_pkg::WAKE_CK_258; // [R16]
                    sel.wd_cycles = osst_pkg::WD_CYC_4MS;
                end
                3'h1: begin
                    sel.wake_cycles = osst_pkg::WAKE_CK_258;
                    sel.wd_cycles = osst_pkg::WD_CYC_64MS;
                end
                3'h2: sel.wake_cycles = osst_pkg::WAKE_CK_1K; // [R17]
                3'h3: begin
                    sel.wake_cycles = osst_pkg::WAKE_CK_1K;
                    sel.wd_cycles = osst_pkg::WD_CYC_4MS;
                end
                3'h4: begin
                    sel.wake_cycles = osst_pkg::WAKE_CK_1K;
                    sel.wd_cycles = osst_pkg::WD_CYC_64MS;
                end
                3'h5: sel.wake_cycles = osst_pkg::WAKE_CK_16K;
                3'h6: begin
                    sel.wake_cycles = osst_pkg::WAKE_CK_16K;
                    sel.wd_cycles = osst_pkg::WD_CYC_4MS;
                end
                3'h7: begin
                    sel.wake_cycles = osst_pkg::WAKE_CK_16K;
                    sel.wd_cycles = osst_pkg::WD_CYC_64MS;
                end
            endcase
        end else begin
            // The 4.1ms and 65ms figures are the same 512 and 8192 watchdog cycles.
            unique case (startup_code) // [R9] [R11]
                2'h0: sel.wd_cycles = (is_rc && reset_pin_disable_fuse) ? osst_pkg::WD_CYC_4MS : 14'h0000; // [R10]
                2'h1: sel.wd_cycles = osst_pkg::WD_CYC_4MS;
                2'h2: sel.wd_cycles = osst_pkg::WD_CYC_64MS;
                2'h3: sel.wd_cycles = 14'h0000; // Reserved code gives the shortest delay.
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register port.

    wire logic wr_trim;
    wire logic wr_mcu;
    wire logic wr_sel;
    wire logic [7:0] status_word;
    wire logic [7:0] rd_mux;

    assign wr_trim = reg_wr && (reg_addr == osst_pkg::ADDR_TRIM);
    assign wr_mcu = reg_wr && (reg_addr == osst_pkg::ADDR_MCU_CTRL);
    assign wr_sel = reg_wr && (reg_addr == osst_pkg::ADDR_CLK_SEL);
    assign status_word = {4'h0, sys_clk_en, rc_enable, state_r};
    assign rd_mux = (reg_addr == osst_pkg::ADDR_TRIM) ? osc_trim_reg_r
        : (reg_addr == osst_pkg::ADDR_MCU_CTRL) ? mcu_control_reg_r
        : (reg_addr == osst_pkg::ADDR_CLK_SEL) ? clock_select_reg_r
        : (reg_addr == osst_pkg::ADDR_STATUS) ? status_word : 8'h00;

    // Fuse-derived values are caught one edge after reset release, never under the reset itself.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            load_pending_r <= 1'b1;
        end else begin
            load_pending_r <= 1'b0;
        end
    end

    // Trim register: factory load after reset, then software writes apply directly.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            osc_trim_reg_r <= 8'h00;
        end else if (load_pending_r) begin
            osc_trim_reg_r <= factory_trim; // [R5]
        end else if (wr_trim) begin
            osc_trim_reg_r <= reg_wdata; // [R6]
        end
    end

    // Control register carrying the RC frequency bit.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mcu_control_reg_r <= 8'h00;
        end else if (load_pending_r) begin
            mcu_control_reg_r <= {7'h00, clock_source_fuses == osst_pkg::SRC_RC_1M}; // [R2]
        end else if (wr_mcu) begin
            mcu_control_reg_r <= reg_wdata;
        end
    end

    // Selection register mirrors the fuses at reset so that switching to it changes nothing.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clock_select_reg_r <= 8'h00;
        end else if (load_pending_r) begin
            clock_select_reg_r <= {2'h0, startup_time_fuses, clock_source_fuses}; // [R12]
        end else if (wr_sel) begin
            clock_select_reg_r <= reg_wdata;
        end
    end

    // Read data stand one cycle after the read strobe and return to zero otherwise.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata_r <= 8'h00;
        end else begin
            reg_rdata_r <= reg_rd ? rd_mux : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Start-up sequencer.

    // A reset start counts 14 source clocks alongside the watchdog delay; a wake uses the source count only.
    always_comb begin
        state_nxt = state_r;
        wake_cnt_nxt = wake_cnt_r;
        wd_cnt_nxt = wd_cnt_r;
        unique case (state_r)
            osst_pkg::ST_IDLE: begin
                if (reset_start_r || wake_req) begin
                    state_nxt = osst_pkg::ST_COUNT;
                    wake_cnt_nxt = reset_start_r ? WAKE_W'(osst_pkg::RESET_CK)
                                                 : WAKE_W'(sel.wake_cycles);
                    wd_cnt_nxt = reset_start_r ? WD_W'(sel.wd_cycles) : '0;
                end
            end
            osst_pkg::ST_COUNT: begin
                if (src_tick && (wake_cnt_r != '0)) begin
                    wake_cnt_nxt = wake_cnt_r - WAKE_W'(1); // [R18]
                end
                if (wd_tick && (wd_cnt_r != '0)) begin
                    wd_cnt_nxt = wd_cnt_r - WD_W'(1); // [R19] [R7]
                end
                if ((wake_cnt_r == '0) && (wd_cnt_r == '0)) begin
                    state_nxt = osst_pkg::ST_RUN; // [R20]
                end
            end
            osst_pkg::ST_RUN: begin
                if (wake_req) begin
                    state_nxt = osst_pkg::ST_COUNT;
                    wake_cnt_nxt = WAKE_W'(sel.wake_cycles);
                end
            end
            default: state_nxt = osst_pkg::ST_IDLE;
        endcase
    end

    // Sequencer registers.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= osst_pkg::ST_IDLE;
            wake_cnt_r <= '0;
            wd_cnt_r <= '0;
            reset_start_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            wake_cnt_r <= wake_cnt_nxt;
            wd_cnt_r <= wd_cnt_nxt;
            reset_start_r <= load_pending_r;
        end
    end

    // Prescaler: one enable in eight when the option is set.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_cnt_r <= 3'h0;
        end else begin
            div_cnt_r <= div_cnt_r + 3'h1; // [R8]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign reg_rdata = reg_rdata_r;
    assign osc_trim = osc_trim_reg_r; // [R6]
    assign rc_freq_select = mcu_control_reg_r[osst_pkg::MCU_RC_FREQ_BIT]; // [R1]
    assign rc_enable = sel.rc_on; // [R3] [R4]
    assign xtal_range = sel.xtal_range; // [R13]
    // The watchdog oscillator stays on whatever source clocks the core.
    assign wd_osc_enable = 1'b1; // [R7]
    assign core_clk_gate = (state_r == osst_pkg::ST_RUN); // [R20]
    assign sys_clk_en = core_clk_gate && (!divide_by_eight_fuse || (div_cnt_r == osst_pkg::DIV8_LAST)); // [R8]

endmodule : osst_top

// File: osst_pkg.sv
// Package with constants, types and timing counts for the oscillator select and start-up timer.
package osst_pkg;

    // Clock source codes with a fixed meaning.
    localparam logic [3:0] SRC_EXT_CLK = 4'h0;
    localparam logic [3:0] SRC_PLL_RC = 4'h1;
    localparam logic [3:0] SRC_RC_8M = 4'h2;
    localparam logic [3:0] SRC_WD_128K = 4'h3;
    localparam logic [3:0] SRC_PLL_XTAL = 4'h4;
    localparam logic [3:0] SRC_PLL_EXT = 4'h5;
    localparam logic [3:0] SRC_RC_1M = 4'h6;
    localparam logic [3:0] SRC_XTAL_C = 4'hC;
    localparam logic [3:0] SRC_XTAL_D = 4'hD;

    // Crystal range codes taken from the upper three source bits.
    localparam logic [2:0] XRANGE_LOW = 3'h4;
    localparam logic [2:0] XRANGE_MID = 3'h5;
    localparam logic [2:0] XRANGE_HIGH = 3'h6;
    localparam logic [2:0] XRANGE_TOP = 3'h7;

    // Register offsets on the plain register port.
    localparam logic [3:0] ADDR_TRIM = 4'h0;
    localparam logic [3:0] ADDR_MCU_CTRL = 4'h1;
    localparam logic [3:0] ADDR_CLK_SEL = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;

    // Field positions.
    localparam int MCU_RC_FREQ_BIT = 0;
    localparam int SEL_FIELD_LO = 0;
    localparam int STARTUP_FIELD_LO = 4;
    localparam int SEL_USE_REG_BIT = 7;

    // Start-up counts, in cycles of the selected source.
    localparam logic [14:0] WAKE_CK_SHORT = 15'h0006;
    localparam logic [14:0] WAKE_CK_258 = 15'h0102;
    localparam logic [14:0] WAKE_CK_1K = 15'h0400;
    localparam logic [14:0] WAKE_CK_16K = 15'h4000;
    localparam logic [14:0] RESET_CK = 15'h000E;

    // Millisecond delays counted on the watchdog oscillator.
    localparam logic [13:0] WD_CYC_4MS = 14'h0200;
    localparam logic [13:0] WD_CYC_64MS = 14'h2000;

    // Prescale figure for the divide-by-eight option.
    localparam logic [2:0] DIV8_LAST = 3'h7;

    // Start-up sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_COUNT = 2'b01,
        ST_RUN = 2'b10
    } osst_state_e;

    // Decoded selection of one source setting.
    typedef struct packed {
        logic rc_on;
        logic [2:0] xtal_range;
        logic [14:0] wake_cycles;
        logic [13:0] wd_cycles;
    } osst_sel_s;

endpackage : osst_pkg

// File: osst_top_assertions.sv
// Concurrent checks on the ports of the oscillator select and start-up timer.
`timescale 1ns/1ps

module osst_top_assertions #(
    parameter int WAKE_W = 15,
    parameter int WD_W = 14
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Configuration and ticks.
    input wire logic [3:0] clock_source_fuses,
    input wire logic [1:0] startup_time_fuses,
    input wire logic divide_by_eight_fuse,
    input wire logic reset_pin_disable_fuse,
    input wire logic [7:0] factory_trim,
    input wire logic src_tick,
    input wire logic wd_tick,
    input wire logic wake_req,
    // Register port.
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Oscillator controls.
    input wire logic rc_enable,
    input wire logic rc_freq_select,
    input wire logic [7:0] osc_trim,
    input wire logic [2:0] xtal_range,
    input wire logic wd_osc_enable,
    input wire logic sys_clk_en,
    input wire logic core_clk_gate
);
    // All checks share one clock domain and its reset.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    wd_osc_on_a: assert property (wd_osc_enable == 1'b1)
        else $error("Watchdog oscillator enable dropped.");
    en_gated_a: assert property (sys_clk_en |-> core_clk_gate)
        else $error("System clock enable while core gated.");
    div8_gap_a: assert property ((divide_by_eight_fuse && sys_clk_en) |=> (!sys_clk_en) [*7])
        else $error("Divided clock enable came too early.");
    nodiv_run_a: assert property ((!divide_by_eight_fuse && core_clk_gate) |-> sys_clk_en)
        else $error("Undivided clock enable missing.");
    trim_write_a: assert property ((reg_wr && reg_addr == osst_pkg::ADDR_TRIM) |=> osc_trim == $past(reg_wdata))
        else $error("Trim write not applied.");
    freq_write_a: assert property ((reg_wr && reg_addr == osst_pkg::ADDR_MCU_CTRL)
        |=> rc_freq_select == $past(reg_wdata[0]))
        else $error("Frequency select write not applied.");
    trim_load_a: assert property ($fell(rst) |=> osc_trim == $past(factory_trim))
        else $error("Calibration byte not loaded at reset.");
    freq_reset_a: assert property ($fell(rst) |=> rc_freq_select == ($past(clock_source_fuses) == 4'h6))
        else $error("Frequency select wrong after reset.");
    gate_hold_a: assert property ($fell(rst) |-> (!core_clk_gate) [*8])
        else $error("Core clock released too early.");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("Read data outside read cycle.");
endmodule : osst_top_assertions

bind osst_top osst_top_assertions #(.WAKE_W(WAKE_W), .WD_W(WD_W)) i_chk (.core_clk(core_clk), .rst(rst),
    .clock_source_fuses(clock_source_fuses), .startup_time_fuses(startup_time_fuses),
    .divide_by_eight_fuse(divide_by_eight_fuse), .reset_pin_disable_fuse(reset_pin_disable_fuse),
    .factory_trim(factory_trim), .src_tick(src_tick), .wd_tick(wd_tick), .wake_req(wake_req),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rc_enable(rc_enable), .rc_freq_select(rc_freq_select), .osc_trim(osc_trim), .xtal_range(xtal_range),
    .wd_osc_enable(wd_osc_enable), .sys_clk_en(sys_clk_en), .core_clk_gate(core_clk_gate));

// File: osc_select_startup_timer_tb.sv
// Self-checking testbench for the oscillator select and start-up timer.
`timescale 1ns/1ps

module osc_select_startup_timer_tb;
    logic core_clk = 1'b0, rst = 1'b1, div8 = 1'b0, rpd = 1'b0, src_tick = 1'b1, wd_tick = 1'b1;
    logic wake_req = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] fsrc = 4'h6, reg_addr = 4'h0;
    logic [1:0] fsut = 2'h0;
    logic [7:0] ftrim = 8'h00, reg_wdata = 8'h00, reg_rdata, osc_trim, rd_v;
    logic rc_enable, rc_freq_select, wd_osc_enable, sys_clk_en, core_clk_gate;
    logic [2:0] xtal_range;
    int fail_count = 0, total_checks = 0, n, k;
    int wake_tab[8] = '{258, 258, 1024, 1024, 1024, 16384, 16384, 16384};

    osst_top i_dut (.core_clk(core_clk), .rst(rst), .clock_source_fuses(fsrc), .startup_time_fuses(fsut),
        .divide_by_eight_fuse(div8), .reset_pin_disable_fuse(rpd), .factory_trim(ftrim), .src_tick(src_tick),
        .wd_tick(wd_tick), .wake_req(wake_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rc_enable(rc_enable), .rc_freq_select(rc_freq_select),
        .osc_trim(osc_trim), .xtal_range(xtal_range), .wd_osc_enable(wd_osc_enable), .sys_clk_en(sys_clk_en),
        .core_clk_gate(core_clk_gate));

    // Clock at 100 MHz.
    always #5 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////////////
    // Compare one value and count it.
    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One write cycle on the register port.
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // One read cycle; data are taken in the cycle after the strobe only.
    task rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    // Counts cycles until the core clock is released; a slack covers pipeline edges.
    task wait_gate(input int lo);
        n = 0;
        while (core_clk_gate === 1'b1 && n < 4) begin
            @(posedge core_clk);
            #1 n++;
        end
        while (core_clk_gate !== 1'b1 && n < 20000) begin
            @(posedge core_clk);
            #1 n++;
        end
        total_checks++;
        if (n < lo || n > lo + 6) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, n, lo);
        end
    endtask : wait_gate

    // Reset with a fuse set, then time the start-up.
    task do_reset(input logic [3:0] s, input logic [1:0] u, input logic p, input logic d, input int lo);
        @(posedge core_clk);
        fsrc <= s;
        fsut <= u;
        rpd <= p;
        div8 <= d;
        ftrim <= {s, 2'h0, u} ^ 8'hA5;
        rst <= 1'b1;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        wait_gate(lo);
    endtask : do_reset

    // Select a source through the register, then time a wake.
    task do_wake(input logic [3:0] s, input logic [1:0] u, input int lo);
        wr(osst_pkg::ADDR_CLK_SEL, {2'h2, u, s});
        @(posedge core_clk);
        wake_req <= 1'b1;
        @(posedge core_clk);
        wake_req <= 1'b0;
        wait_gate(lo - 1);
    endtask : do_wake

    // Print the counts and the verdict, then stop.
    task final_report;
        $display("Checks %0d, errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        do_reset(4'h6, 2'h0, 1'b0, 1'b0, 14);
        rd(osst_pkg::ADDR_TRIM, rd_v); chk(rd_v, 8'h60 ^ 8'hA5);
        rd(osst_pkg::ADDR_MCU_CTRL, rd_v); chk(rd_v, 8'h01);
        rd(osst_pkg::ADDR_CLK_SEL, rd_v); chk(rd_v, 8'h06);
        rd(4'hF, rd_v); chk(rd_v, 8'h00);
        rd(osst_pkg::ADDR_STATUS, rd_v); chk(rd_v, 8'h0E);
        chk({7'h0, wd_osc_enable}, 8'h01);
        wr(osst_pkg::ADDR_TRIM, 8'h3C); rd(osst_pkg::ADDR_TRIM, rd_v); chk(rd_v, 8'h3C);
        chk(osc_trim, 8'h3C);
        wr(osst_pkg::ADDR_MCU_CTRL, 8'h00); #1 chk({7'h0, rc_freq_select}, 8'h00);
        wr(osst_pkg::ADDR_MCU_CTRL, 8'h01); #1 chk({7'h0, rc_freq_select}, 8'h01);
        // Every source code through the selection register.
        for (k = 0; k < 16; k++) begin
            wr(osst_pkg::ADDR_CLK_SEL, {4'h8, 4'(k)});
            #1 chk({7'h0, rc_enable}, {7'h0, !(k inside {3, 4, 5, 12, 13})});
            chk({5'h0, xtal_range}, (k >= 7) ? {5'h0, 3'(k >> 1)} : 8'h00);
        end
        do_wake(4'h2, 2'h0, 6);
        do_wake(4'h3, 2'h2, 6);
        for (k = 0; k < 8; k++) begin
            do_wake({3'h6, 1'(k >> 2)}, 2'(k), wake_tab[k]);
        end
        do_reset(4'h2, 2'h1, 1'b0, 1'b1, 512);
        k = 0;
        repeat (64) begin
            @(posedge core_clk);
            #1 k += int'(sys_clk_en === 1'b1);
        end
        chk(8'(k), 8'h08);
        do_reset(4'h2, 2'h0, 1'b1, 1'b0, 512);
        do_reset(4'h3, 2'h2, 1'b0, 1'b0, 8192);
        do_reset(4'hC, 2'h1, 1'b0, 1'b0, 8192);
        final_report();
    end

    // Watchdog well past the longest expected run.
    initial begin
        #900000;
        fail_count++;
        final_report();
    end
endmodule : osc_select_startup_timer_tb
